// ==== include/bsp_pkg.sv ====
// constants and types shared by the sequencing and protection block
package bsp_pkg;

  // ***********************************************************
  // bus map
  // ***********************************************************
  localparam logic [7:0]  ADDR_CTRL   = 8'h00;
  localparam logic [7:0]  ADDR_STATUS = 8'h04;
  localparam logic [7:0]  ADDR_CFG    = 8'h08;
  localparam logic [31:0] CTRL_RST    = 32'h0000_0000;
  localparam logic [31:0] CFG_RST     = 32'h0000_0000;
  localparam int          CTRL_SKIP_BIT   = 0;
  localparam int          CFG_TMIN_LSB    = 0;
  localparam logic [1:0]  HTRANS_NONSEQ   = 2'b10;
  localparam logic [1:0]  HSIZE_WORD      = 2'b10;
  localparam logic [1:0]  HRESP_OKAY      = 2'b00;

  // ***********************************************************
  // timing
  // ***********************************************************
  localparam int MCLK_HZ        = 20_000_000;
  localparam int START_DLY_US   = 500;
  localparam int START_DLY_CYC  = (START_DLY_US * (MCLK_HZ / 1000) + 999) / 1000;
  localparam int RAMP_PERIODS   = 1024;
  localparam int MIN_ON_NS      = 130;
  localparam int MIN_ON_CYC     = (MIN_ON_NS * (MCLK_HZ / 1_000_000) + 999) / 1000;
  localparam int OC_RUN_LEN     = 4;
  localparam int DEAD_WDOG_CYC  = 4;
  localparam int REF_W          = 10;

  // ***********************************************************
  // sequencer states
  // ***********************************************************
  typedef enum logic [4:0]
  {
    ST_OFF   = 5'b00001,
    ST_DELAY = 5'b00010,
    ST_RAMP  = 5'b00100,
    ST_RUN   = 5'b01000,
    ST_LATCH = 5'b10000
  } bsp_state_e;

endpackage : bsp_pkg

// ==== include/bsp_drv_if.sv ====
// gate request and feedback bundle between sequencer and dead-time stage
`timescale 1ns/100ps
interface bsp_drv_if;
  logic upper_req;
  logic lower_req;
  logic node_low;
  logic lower_gate_fb;
  logic upper_on;
  logic lower_on;
  modport ctl (output upper_req, output lower_req,
               output node_low, output lower_gate_fb,
               input upper_on, input lower_on);
  modport drv (input upper_req, input lower_req,
               input node_low, input lower_gate_fb,
               output upper_on, output lower_on);
endinterface : bsp_drv_if

// ==== hdl/bsp_deadtime.sv ====
// break-before-make gate stage with lower-switch watchdog
`timescale 1ns/100ps
module bsp_deadtime
#(
  parameter int WDOG_CYC = bsp_pkg::DEAD_WDOG_CYC
)
(
  // clock and reset
  input  wire logic mclk_i,
  input  wire logic rst_n_i,
  // gate bundle
  bsp_drv_if.drv    drv
);

  logic [7:0] wdog_r;
  logic       upper_r;
  logic       lower_r;

  assign drv.upper_on = upper_r;
  assign drv.lower_on = lower_r;

  // upper only once lower gate has fallen
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      upper_r <= 1'b0;
    else
      upper_r <= drv.upper_req && !drv.lower_req && !drv.lower_gate_fb;
  end

  // lower once node falls, or on watchdog with negative current
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      lower_r <= 1'b0;
    else if (!drv.lower_req || drv.upper_req)
      lower_r <= 1'b0;
    else if (drv.node_low || wdog_r >= 8'(WDOG_CYC))
      lower_r <= 1'b1;
  end

  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      wdog_r <= 8'h00;
    else if (!drv.lower_req || drv.upper_req || lower_r)
      wdog_r <= 8'h00;
    else if (wdog_r < 8'(WDOG_CYC))
      wdog_r <= wdog_r + 8'h01;
  end

endmodule // bsp_deadtime

// ==== hdl/bsp_seq_prot.sv ====
// sequencing and protection controller of a step-down regulator
// Behaviour
// - after supplies valid and enable high, wait 0.5 ms before ramp
// - reference ramps linearly to full scale over 1024 switching periods
// - lower switch masked during ramp until first upper pulse
// - without an upper pulse, lower switch enabled at ramp end
// - overvoltage may still turn lower switch on during masking
// - soft-off turns both switches off and connects bleed resistor
// - soft-off latch on signal lockout, any protection, or enable low
// - latch clears only by cycling enable, signal supply or power supply
// - overvoltage and overcurrent armed once enabled and supplies valid
// - feedback above overvoltage threshold forces upper switch off
// - after overvoltage lower on until feedback below 0.3 V, repeats
// - overvoltage state latched until enable or supply cycled
// - undervoltage armed from ramp end; trip starts soft-off
// - undervoltage latch released by enable or either supply cycling
// - regulation output released only after ramp done and in window
// - regulation output low on window exit, disable, lockout, protection
// - current sense uses lower switch when on-time below 130 ns
// - first-level current ends upper pulse, lower on until next cycle
// - four consecutive first-level cycles trip overcurrent; clean cycle resets
// - second-level current trips overcurrent at once
// - overcurrent: upper off, lower on until 600 mA, then both off
// - break-before-make gating with watchdog for negative current
`timescale 1ns/100ps
module bsp_seq_prot
#(
  parameter int START_DLY_CYC = bsp_pkg::START_DLY_CYC,
  parameter int RAMP_PERIODS  = bsp_pkg::RAMP_PERIODS,
  parameter int MIN_ON_CYC    = bsp_pkg::MIN_ON_CYC,
  parameter int OC_RUN_LEN    = bsp_pkg::OC_RUN_LEN
)
(
  // clock and reset
  input  wire logic        mclk_i,
  input  wire logic        rst_n_i,
  // ahb-lite slave
  input  wire logic        hsel_i,
  input  wire logic [7:0]  haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic [31:0] hwdata_i,
  input  wire logic        hready_i,
  output logic      [31:0] hrdata_o,
  output logic             hreadyout_o,
  output logic             hresp_o,
  // supervision inputs
  input  wire logic        enable_i,
  input  wire logic        signal_supply_ok_i,
  input  wire logic        power_supply_ok_i,
  // feedback_sense comparators
  input  wire logic        fb_above_ovp_i,
  input  wire logic        fb_below_ov_release_i,
  input  wire logic        fb_below_uvp_i,
  input  wire logic        fb_in_window_i,
  // current comparators and loop
  input  wire logic        sw_clk_i,
  input  wire logic        pwm_i,
  input  wire logic        upper_oc1_i,
  input  wire logic        lower_oc1_i,
  input  wire logic        upper_oc2_i,
  input  wire logic        lower_oc2_i,
  input  wire logic        current_below_600ma_i,
  // power stage
  input  wire logic        node_low_i,
  input  wire logic        lower_gate_fb_i,
  output logic             upper_switch_o,
  output logic             lower_switch_o,
  output logic             bleed_on_o,
  output logic [9:0]       ref_level_o,
  // regulation_ok_output, open drain
  output logic             regulation_ok_output_o,
  output logic             regulation_ok_output_oe_o
);

  // ***********************************************************
  // state and protection latches
  // ***********************************************************
  bsp_pkg::bsp_state_e state_r;
  bsp_pkg::bsp_state_e state_nxt;
  logic [23:0] dly_r;
  logic [10:0] ramp_r;
  logic [9:0]  ref_r;
  logic        sw_clk_d_r;
  logic        pwm_d_r;
  logic        first_pulse_r;
  logic        ovp_r;
  logic        ovp_lower_r;
  logic        uvp_r;
  logic        ocp_r;
  logic        ocp_drain_r;
  logic        oc1_cycle_r;
  logic        oc1_hold_r;
  logic [2:0]  oc_run_r;
  logic [7:0]  on_cnt_r;
  logic        short_on_r;
  logic        skip_en_r;
  logic [7:0]  tmin_r;
  logic [31:0] hrdata_r;
  logic        wr_pend_r;
  logic [7:0]  wr_addr_r;

  logic armed;
  logic period_tick;
  logic pwm_rise;
  logic oc1;
  logic oc2;
  logic fault;

  bsp_drv_if drv_if ();

  assign armed       = enable_i && signal_supply_ok_i && power_supply_ok_i;
  assign period_tick = sw_clk_i && !sw_clk_d_r;
  assign pwm_rise    = pwm_i && !pwm_d_r;
  assign oc1 = short_on_r ? lower_oc1_i : upper_oc1_i;
  assign oc2 = short_on_r ? lower_oc2_i : upper_oc2_i;
  assign fault = ovp_r || uvp_r || ocp_r;

  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      sw_clk_d_r <= 1'b0;
      pwm_d_r    <= 1'b0;
    end
    else
    begin
      sw_clk_d_r <= sw_clk_i;
      pwm_d_r    <= pwm_i;
    end
  end

  // ***********************************************************
  // sequencer
  // ***********************************************************
  always_comb
  begin
    state_nxt = state_r;
    unique case (state_r)
      bsp_pkg::ST_OFF:
        if (armed)
          state_nxt = bsp_pkg::ST_DELAY;
      bsp_pkg::ST_DELAY:
        if (!armed || fault)
          state_nxt = bsp_pkg::ST_LATCH;
        else if (dly_r >= 24'(START_DLY_CYC - 1))
          state_nxt = bsp_pkg::ST_RAMP;
      bsp_pkg::ST_RAMP:
        if (!armed || fault)
          state_nxt = bsp_pkg::ST_LATCH;
        else if (ramp_r >= 11'(RAMP_PERIODS))
          state_nxt = bsp_pkg::ST_RUN;
      bsp_pkg::ST_RUN:
        if (!armed || fault)
          state_nxt = bsp_pkg::ST_LATCH;
      bsp_pkg::ST_LATCH:
        // release needs enable or a supply to drop first
        if (!enable_i || !signal_supply_ok_i || !power_supply_ok_i)
          state_nxt = bsp_pkg::ST_OFF;
      default:
        state_nxt = bsp_pkg::ST_LATCH;
    endcase
  end

  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      state_r <= bsp_pkg::ST_OFF;
    else
      state_r <= state_nxt;
  end

  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      dly_r <= 24'h00_0000;
    else if (state_r == bsp_pkg::ST_DELAY)
      dly_r <= dly_r + 24'h00_0001;
    else
      dly_r <= 24'h00_0000;
  end

  // reference steps once per switching period
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      ramp_r <= 11'h000;
      ref_r  <= 10'h000;
    end
    else if (state_r == bsp_pkg::ST_RAMP)
    begin
      if (period_tick && ramp_r < 11'(RAMP_PERIODS))
      begin
        ramp_r <= ramp_r + 11'h001;
        ref_r  <= ramp_r[9:0];
      end
    end
    else if (state_r == bsp_pkg::ST_RUN)
      ref_r <= 10'h3ff;
    else
    begin
      ramp_r <= 11'h000;
      ref_r  <= 10'h000;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      first_pulse_r <= 1'b0;
    else if (state_r == bsp_pkg::ST_OFF)
      first_pulse_r <= 1'b0;
    else if (state_r == bsp_pkg::ST_RAMP && pwm_rise)
      first_pulse_r <= 1'b1;
  end

  // ***********************************************************
  // protection
  // ***********************************************************
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      ovp_r       <= 1'b0;
      ovp_lower_r <= 1'b0;
    end
    else if (state_r == bsp_pkg::ST_OFF)
    begin
      ovp_r       <= 1'b0;
      ovp_lower_r <= 1'b0;
    end
    else if (armed && fb_above_ovp_i)
    begin
      ovp_r       <= 1'b1;
      ovp_lower_r <= 1'b1;
    end
    else if (fb_below_ov_release_i)
      ovp_lower_r <= 1'b0;
  end

  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      uvp_r <= 1'b0;
    else if (state_r == bsp_pkg::ST_OFF)
      uvp_r <= 1'b0;
    else if (state_r == bsp_pkg::ST_RUN && fb_below_uvp_i)
      uvp_r <= 1'b1;
  end

  // on-time measured in clock periods against the short-pulse limit
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      on_cnt_r   <= 8'h00;
      short_on_r <= 1'b0;
    end
    else if (pwm_i)
      on_cnt_r <= (on_cnt_r == 8'hff) ? on_cnt_r : on_cnt_r + 8'h01;
    else if (pwm_d_r)
    begin
      short_on_r <= on_cnt_r < tmin_r;
      on_cnt_r   <= 8'h00;
    end
  end

  // first-level events per period, run length of consecutive periods
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      oc1_cycle_r <= 1'b0;
      oc1_hold_r  <= 1'b0;
      oc_run_r    <= 3'h0;
    end
    else if (state_r == bsp_pkg::ST_OFF)
    begin
      oc1_cycle_r <= 1'b0;
      oc1_hold_r  <= 1'b0;
      oc_run_r    <= 3'h0;
    end
    else if (period_tick)
    begin
      oc1_hold_r  <= oc1;
      oc1_cycle_r <= oc1;
      if (oc1_cycle_r || oc1)
        oc_run_r <= (oc_run_r == 3'h7) ? oc_run_r : oc_run_r + 3'h1;
      else
        oc_run_r <= 3'h0;
    end
    else if (armed && oc1)
    begin
      oc1_cycle_r <= 1'b1;
      oc1_hold_r  <= 1'b1;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      ocp_r       <= 1'b0;
      ocp_drain_r <= 1'b0;
    end
    else if (state_r == bsp_pkg::ST_OFF)
    begin
      ocp_r       <= 1'b0;
      ocp_drain_r <= 1'b0;
    end
    else if (armed && !ocp_r
             && (oc2 || oc_run_r >= 3'(OC_RUN_LEN)))
    begin
      ocp_r       <= 1'b1;
      ocp_drain_r <= 1'b1;
    end
    else if (current_below_600ma_i)
      ocp_drain_r <= 1'b0;
  end

  // ***********************************************************
  // gate requests
  // ***********************************************************
  logic running;
  logic lower_loop_ok;
  assign running = state_r == bsp_pkg::ST_RAMP || state_r == bsp_pkg::ST_RUN;
  // masking only applies to loop requests; skip mode forbids sinking
  assign lower_loop_ok = (state_r == bsp_pkg::ST_RUN || first_pulse_r)
                         && !skip_en_r;

  always_comb
  begin
    drv_if.upper_req = 1'b0;
    drv_if.lower_req = 1'b0;
    if (ocp_r)
      drv_if.lower_req = ocp_drain_r;
    else if (ovp_r)
      drv_if.lower_req = ovp_lower_r;
    else if (running && !uvp_r)
    begin
      if (oc1_hold_r)
        drv_if.lower_req = 1'b1;
      else
      begin
        drv_if.upper_req = pwm_i;
        drv_if.lower_req = !pwm_i && lower_loop_ok;
      end
    end
  end

  assign drv_if.node_low      = node_low_i;
  assign drv_if.lower_gate_fb = lower_gate_fb_i;

  bsp_deadtime u_dead
  (
    .mclk_i  (mclk_i),
    .rst_n_i (rst_n_i),
    .drv     (drv_if.drv)
  );

  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      upper_switch_o <= 1'b0;
      lower_switch_o <= 1'b0;
      bleed_on_o     <= 1'b0;
      ref_level_o    <= 10'h000;
      regulation_ok_output_oe_o <= 1'b1;
    end
    else
    begin
      upper_switch_o <= drv_if.upper_on;
      lower_switch_o <= drv_if.lower_on;
      // bleed waits until both gates have dropped, never overlaps a switch
      bleed_on_o     <= state_r == bsp_pkg::ST_LATCH && !drv_if.lower_on
                        && !drv_if.upper_on;
      ref_level_o    <= ref_r;
      regulation_ok_output_oe_o <= !(state_r == bsp_pkg::ST_RUN && armed
                                   && !fault && fb_in_window_i);
    end
  end
  assign regulation_ok_output_o = 1'b0;

  // ***********************************************************
  // ahb-lite slave, zero wait states
  // ***********************************************************
  logic addr_ok;
  assign addr_ok = hsel_i && hready_i && htrans_i[1];
  assign hreadyout_o = 1'b1;
  assign hresp_o     = 1'b0;
  assign hrdata_o    = hrdata_r;

  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
      hrdata_r  <= 32'h0000_0000;
    end
    else
    begin
      wr_pend_r <= addr_ok && hwrite_i;
      wr_addr_r <= haddr_i;
      if (addr_ok && !hwrite_i)
        unique case (haddr_i)
          bsp_pkg::ADDR_CTRL:
            hrdata_r <= {31'h0000_0000, skip_en_r};
          bsp_pkg::ADDR_STATUS:
            hrdata_r <= {20'h0_0000, first_pulse_r, short_on_r, ocp_r, uvp_r,
                         ovp_r, bleed_on_o, ~regulation_ok_output_oe_o,
                         state_r};
          bsp_pkg::ADDR_CFG:
            hrdata_r <= {24'h00_0000, tmin_r};
          default:
            hrdata_r <= 32'h0000_0000;
        endcase
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      skip_en_r <= bsp_pkg::CTRL_RST[bsp_pkg::CTRL_SKIP_BIT];
      tmin_r    <= 8'(MIN_ON_CYC);
    end
    else if (wr_pend_r && wr_addr_r == bsp_pkg::ADDR_CTRL)
      skip_en_r <= hwdata_i[bsp_pkg::CTRL_SKIP_BIT];
    else if (wr_pend_r && wr_addr_r == bsp_pkg::ADDR_CFG)
      tmin_r <= hwdata_i[bsp_pkg::CFG_TMIN_LSB +: 8];
  end

endmodule // bsp_seq_prot

// ==== testbench/bsp_seq_prot_sva.sv ====
// assertion checker for the sequencing and protection block
`timescale 1ns/100ps
module bsp_seq_prot_chk
(
  // clock and reset
  input wire logic       mclk_i,
  input wire logic       rst_n_i,
  // supervision and sense
  input wire logic       enable_i,
  input wire logic       signal_supply_ok_i,
  input wire logic       power_supply_ok_i,
  input wire logic       fb_above_ovp_i,
  input wire logic       fb_in_window_i,
  input wire logic       upper_oc2_i,
  input wire logic       lower_oc2_i,
  // outputs
  input wire logic       upper_switch_o,
  input wire logic       lower_switch_o,
  input wire logic       bleed_on_o,
  input wire logic [9:0] ref_level_o,
  input wire logic       regulation_ok_output_o,
  input wire logic       regulation_ok_output_oe_o
);
  // ****
  // properties
  // ****
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  logic armed;
  assign armed = enable_i && signal_supply_ok_i && power_supply_ok_i;
  chk_ovp_upper_off: assert property (
    armed && fb_above_ovp_i |-> ##[0:3] !upper_switch_o)
    else $error("upper switch stays on in overvoltage");
  chk_oc2_upper_off: assert property (
    armed && (upper_oc2_i || lower_oc2_i) |-> ##[0:3] !upper_switch_o)
    else $error("upper switch stays on in overcurrent");
  chk_no_overlap: assert property (
    !(upper_switch_o && lower_switch_o))
    else $error("both switches on");
  chk_bleed_off: assert property (
    bleed_on_o |-> !upper_switch_o && !lower_switch_o)
    else $error("bleed connected with a switch on");
  chk_pg_disable: assert property (
    $fell(enable_i) |-> ##[0:3] regulation_ok_output_oe_o)
    else $error("power good not pulled low on disable");
  chk_pg_lockout: assert property (
    !signal_supply_ok_i |-> ##[0:3] regulation_ok_output_oe_o)
    else $error("power good not pulled low on lockout");
  chk_pg_window: assert property (
    !fb_in_window_i |-> ##[0:3] regulation_ok_output_oe_o)
    else $error("power good not pulled low out of window");
  chk_pg_open_drain: assert property (
    regulation_ok_output_o == 1'b0)
    else $error("power good driven high");
  cover property ($rose(bleed_on_o));
  cover property (ref_level_o == 10'h3ff);
  cover property ($fell(regulation_ok_output_oe_o));
endmodule // bsp_seq_prot_chk

bind bsp_seq_prot bsp_seq_prot_chk u_chk
(
  .mclk_i, .rst_n_i, .enable_i, .signal_supply_ok_i, .power_supply_ok_i,
  .fb_above_ovp_i, .fb_in_window_i, .upper_oc2_i, .lower_oc2_i,
  .upper_switch_o, .lower_switch_o, .bleed_on_o, .ref_level_o,
  .regulation_ok_output_o, .regulation_ok_output_oe_o
);

// ==== testbench/bsp_load_model.sv ====
// far-side model: switching clock and power-stage feedback
`timescale 1ns/100ps
module bsp_load_model
(
  // clock and reset
  input  wire logic mclk_i,
  input  wire logic rst_n_i,
  // gate commands and load condition
  input  wire logic upper_i,
  input  wire logic lower_i,
  input  wire logic neg_cur_i,
  // feedback to the block
  output logic      sw_clk_o,
  output logic      node_low_o,
  output logic      lower_gate_fb_o
);
  logic [2:0] div_r;
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      div_r <= 3'h0;
    else
      div_r <= div_r + 3'h1;
  end
  assign sw_clk_o = div_r[2];
  // negative current holds the node high: only the watchdog frees lower
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      node_low_o      <= 1'b0;
      lower_gate_fb_o <= 1'b0;
    end
    else
    begin
      node_low_o      <= !upper_i && !neg_cur_i;
      lower_gate_fb_o <= lower_i;
    end
  end
endmodule // bsp_load_model

// ==== testbench/bsp_seq_prot_tb.sv ====
// self-checking bench for the sequencing and protection block
`timescale 1ns/100ps
module bsp_seq_prot_tb;
  logic        mclk_i, rst_n_i, hsel_i, hwrite_i, hreadyout_o, hresp_o;
  logic [7:0]  haddr_i;
  logic [1:0]  htrans_i;
  logic [31:0] hwdata_i, hrdata_o, rd;
  logic        en, vcc_ok, vin_ok, overvoltage_trip, ovrel, undervoltage_trip, win, pwm;
  logic        uoc1, loc1, uoc2, loc2, c600, neg;
  logic        sw_clk, node_low, lg_fb, up, lo, bleed, pg, pg_oe;
  logic [9:0]  ref_lvl;
  int          error_cnt, n_checks;
  bsp_seq_prot #(.START_DLY_CYC(20), .RAMP_PERIODS(8)) dut
  (
    .mclk_i, .rst_n_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i,
    .hsize_i({1'b0, bsp_pkg::HSIZE_WORD}), .hwdata_i,
    .hready_i(hreadyout_o), .hrdata_o, .hreadyout_o, .hresp_o,
    .enable_i(en), .signal_supply_ok_i(vcc_ok), .power_supply_ok_i(vin_ok),
    .fb_above_ovp_i(overvoltage_trip), .fb_below_ov_release_i(ovrel),
    .fb_below_uvp_i(undervoltage_trip), .fb_in_window_i(win), .sw_clk_i(sw_clk),
    .pwm_i(pwm), .upper_oc1_i(uoc1), .lower_oc1_i(loc1),
    .upper_oc2_i(uoc2), .lower_oc2_i(loc2),
    .current_below_600ma_i(c600), .node_low_i(node_low),
    .lower_gate_fb_i(lg_fb), .upper_switch_o(up), .lower_switch_o(lo),
    .bleed_on_o(bleed), .ref_level_o(ref_lvl),
    .regulation_ok_output_o(pg), .regulation_ok_output_oe_o(pg_oe)
  );
  bsp_load_model u_load
  (
    .mclk_i, .rst_n_i, .upper_i(up), .lower_i(lo), .neg_cur_i(neg),
    .sw_clk_o(sw_clk), .node_low_o(node_low), .lower_gate_fb_o(lg_fb)
  );
  // ****
  // tasks
  // ****
  task automatic final_report;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    n_checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("FAIL %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic clk(input int n);
    repeat (n) @(posedge mclk_i);
  endtask
  // one single transfer; always entered just after a rising edge
  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd);
    hsel_i   <= 1'b1;
    haddr_i  <= a;
    htrans_i <= bsp_pkg::HTRANS_NONSEQ;
    hwrite_i <= wr;
    do clk(1); while (hreadyout_o !== 1'b1);
    hsel_i   <= 1'b0;
    htrans_i <= 2'b00;
    hwdata_i <= wd;
    do clk(1); while (hreadyout_o !== 1'b1);
    rd = hrdata_o;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] m, exp,
                      input string nm);
    bus(1'b0, a, 32'h0000_0000);
    chk(nm, rd & m, exp);
    chk("hresp", 32'(hresp_o), 32'(bsp_pkg::HRESP_OKAY));
  endtask
  task automatic wait_st(input logic [4:0] st);
    int i;
    i = 0;
    do
    begin
      bus(1'b0, bsp_pkg::ADDR_STATUS, 32'h0000_0000);
      i++;
    end
    while (i < 100 && rd[4:0] !== st);
    chk("state", {27'h0, rd[4:0]}, {27'h0, st});
  endtask
  // ****
  // stimulus
  // ****
  initial
  begin
    mclk_i = 1'b0;
    forever #25 mclk_i = ~mclk_i;
  end
  initial
  begin
    clk(10000);
    error_cnt++;
    final_report;
  end
  initial
  begin
    {rst_n_i, hsel_i, hwrite_i, haddr_i, htrans_i, hwdata_i} = '0;
    {en, vcc_ok, vin_ok, overvoltage_trip, ovrel, undervoltage_trip, pwm} = '0;
    {uoc1, loc1, uoc2, loc2, c600, neg} = '0;
    win = 1'b1;
    error_cnt = 0;
    n_checks = 0;
    clk(6);
    rst_n_i <= 1'b1;
    clk(1);
    rchk(bsp_pkg::ADDR_CTRL, 32'hffff_ffff, bsp_pkg::CTRL_RST, "ctrl");
    rchk(8'h0c, 32'hffff_ffff, 32'h0000_0000, "unmapped");
    bus(1'b1, bsp_pkg::ADDR_CFG, 32'h0000_0005);
    rchk(bsp_pkg::ADDR_CFG, 32'h0000_00ff, 32'h0000_0005, "cfg");
    wait_st(bsp_pkg::ST_OFF);
    chk("pg off", 32'(pg_oe), 32'h0000_0001);
    {en, vcc_ok, vin_ok} <= 3'b111;
    clk(10);
    wait_st(bsp_pkg::ST_DELAY);
    wait_st(bsp_pkg::ST_RAMP);
    undervoltage_trip <= 1'b1;
    clk(4);
    chk("lower masked", 32'(lo), 32'h0000_0000);
    rchk(bsp_pkg::ADDR_STATUS, 32'h0000_011f, 32'h0000_0004, "uv");
    undervoltage_trip <= 1'b0;
    wait_st(bsp_pkg::ST_RUN);
    clk(2);
    chk("ref", 32'(ref_lvl), 32'h0000_03ff);
    clk(8);
    chk("lower end", 32'(lo), 32'h0000_0001);
    chk("pg run", 32'(pg_oe), 32'h0000_0000);
    win <= 1'b0;
    clk(4);
    chk("pg win", 32'(pg_oe), 32'h0000_0001);
    win <= 1'b1;
    bus(1'b1, bsp_pkg::ADDR_CTRL, 32'h0000_0001);
    clk(8);
    chk("skip", 32'(lo), 32'h0000_0000);
    bus(1'b1, bsp_pkg::ADDR_CTRL, 32'h0000_0000);
    pwm <= 1'b1;
    clk(8);
    chk("pulse", 32'(up), 32'h0000_0001);
    pwm <= 1'b0;
    @(posedge sw_clk);
    clk(3);
    {uoc1, loc1} <= 2'b11;
    clk(16);
    {uoc1, loc1} <= 2'b00;
    clk(16);
    wait_st(bsp_pkg::ST_RUN);
    {uoc1, loc1} <= 2'b11;
    clk(40);
    wait_st(bsp_pkg::ST_LATCH);
    rchk(bsp_pkg::ADDR_STATUS, 32'h0000_0200, 32'h0000_0200, "oc");
    chk("oc lower", {31'h0, lo}, 32'h0000_0001);
    c600 <= 1'b1;
    {uoc1, loc1} <= 2'b00;
    clk(8);
    chk("oc both", {30'h0, up, lo}, 32'h0000_0000);
    chk("bleed", 32'(bleed), 32'h0000_0001);
    en <= 1'b0;
    wait_st(bsp_pkg::ST_OFF);
    en <= 1'b1;
    wait_st(bsp_pkg::ST_DELAY);
    {neg, overvoltage_trip} <= 2'b11;
    wait_st(bsp_pkg::ST_LATCH);
    rchk(bsp_pkg::ADDR_STATUS, 32'h0000_0080, 32'h0000_0080, "ov");
    clk(8);
    chk("ov lower", 32'(lo), 32'h0000_0001);
    {overvoltage_trip, ovrel} <= 2'b01;
    clk(8);
    chk("ov rel", 32'(lo), 32'h0000_0000);
    {overvoltage_trip, ovrel} <= 2'b10;
    clk(8);
    chk("ov again", 32'(lo), 32'h0000_0001);
    {overvoltage_trip, ovrel, neg} <= 3'b010;
    vcc_ok <= 1'b0;
    wait_st(bsp_pkg::ST_OFF);
    vcc_ok <= 1'b1;
    wait_st(bsp_pkg::ST_RUN);
    pwm <= 1'b1;
    {uoc2, loc2} <= 2'b11;
    clk(3);
    {uoc2, loc2} <= 2'b00;
    wait_st(bsp_pkg::ST_LATCH);
    rchk(bsp_pkg::ADDR_STATUS, 32'h0000_0200, 32'h0000_0200, "oc2");
    pwm <= 1'b0;
    vin_ok <= 1'b0;
    wait_st(bsp_pkg::ST_OFF);
    vin_ok <= 1'b1;
    wait_st(bsp_pkg::ST_RUN);
    undervoltage_trip <= 1'b1;
    wait_st(bsp_pkg::ST_LATCH);
    rchk(bsp_pkg::ADDR_STATUS, 32'h0000_0100, 32'h0000_0100, "uvp");
    final_report;
  end
endmodule // bsp_seq_prot_tb
